/* File: rtl/uart_pins_pkg.sv */
package uart_pins_pkg;

   // register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [3:0] OFS_IRQ_EN    = 4'h1;
   localparam logic [3:0] OFS_FIFO_CTRL = 4'h2;
   localparam logic [3:0] OFS_MODEM_CTL = 4'h4;
   localparam logic [3:0] OFS_MODEM_STS = 4'h6;
   localparam logic [3:0] OFS_EVT_STS   = 4'h8;
   localparam logic [3:0] OFS_EVT_EN    = 4'h9;
   localparam logic [3:0] OFS_EVT_CLR   = 4'ha;

   // modem status register fields
   localparam int MSR_RING_RISE = 2;
   localparam int MSR_RING_LVL  = 6;

   // modem control register fields
   localparam int MCR_RTS      = 1;
   localparam int MCR_LOOPBACK = 4;

   // fifo control register fields
   localparam int FCR_FIFO_EN  = 0;
   localparam int FCR_DMA_MODE = 3;

   // interrupt enable register fields
   localparam int IER_MODEM_STS = 3;

   // event status bits (status, enable and clear share the layout)
   localparam int EVT_RING_RISE = 0;
   localparam int EVT_DMA_REQ   = 1;
   localparam int EVT_W         = 2;

   // reset values
   localparam logic [7:0] RST_REG   = 8'h00;
   localparam logic       RST_HIGH  = 1'b1;
   localparam logic       RST_LOW   = 1'b0;

   // register bus request carried as one bundle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   // receive path state coming from the fifo logic
   typedef struct packed {
      logic data_avail;
      logic trigger_hit;
      logic timeout_hit;
   } rx_state_t;

   // receive dma mode 1 request tracker
   typedef enum logic [0:0] {
      DMA_IDLE   = 1'b0,
      DMA_ACTIVE = 1'b1
   } dma_state_t;

endpackage

/* File: rtl/pin_sync3.sv */
`timescale 1ns/1ps

// three stage synchroniser with agreement filter
module pin_sync3
   import uart_pins_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic pin_in,
   output logic      level_r
);

   logic ff1_r;   // metastable stage, read only by ff2
   logic ff2_r;   // first settled stage
   logic ff3_r;   // second settled stage

   // shift chain; the first stage feeds nothing but ff2
   // stages start at the pin's pulled-up idle level, so no false edge follows reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ff1_r <= RST_HIGH;
         ff2_r <= RST_HIGH;
         ff3_r <= RST_HIGH;
      end else begin
         ff1_r <= pin_in;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
      end
   end

   // a new level counts only once two settled stages agree
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         level_r <= RST_HIGH;
      end else if (ff2_r == ff3_r) begin
         level_r <= ff3_r;
      end
   end

endmodule

/* File: rtl/uart_modem_rx_dma_pins.sv */
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - ring level readable in status bit 6
// - ring rise sets status bit 2
// - enabled ring rise raises interrupt
// - rts bit set drives rts active
// - rts inactive at reset, loopback, clear
// - rts never affects transmit or receive
// - fcr bit 3 picks dma mode while fcr bit 0 enables the fifo
// - mode 0 request while data present
// - mode 1 request on trigger, until empty
// - serial output marking high at reset
// - interrupt high while pending, reset clears
module uart_modem_rx_dma_pins
   import uart_pins_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire reg_req_t          reg_req,
   output logic [DATA_W-1:0]      reg_rdata,
   input  wire rx_state_t         rx_state,
   input  wire logic              tx_serial_bit,
   input  wire logic              ring_in_n,
   output logic                   rts_n,
   output logic                   rx_dma_request_n,
   output logic                   tx_out,
   output logic                   irq,
   output logic                   loopback
);

   // software visible registers
   logic [DATA_W-1:0] modem_control_reg;   // rts and loopback control
   logic [DATA_W-1:0] fifo_control_reg;    // fifo enable and dma mode
   logic [DATA_W-1:0] irq_enable_r;        // modem status interrupt enable
   logic [EVT_W-1:0]  evt_status_r;        // sticky event bits
   logic [EVT_W-1:0]  evt_enable_r;        // event interrupt mask

   // ring indicator path
   logic              ring_sync_n;         // filtered pin level, low active
   logic              ring_level;          // ring asserted, high active
   logic              ring_prev_r;         // previous filtered level
   logic              ring_rise;           // one cycle low to high pulse
   logic              ring_rise_flag;      // change flag since last read

   // bus decode
   logic              msr_read;            // modem status read strobe
   logic [DATA_W-1:0] msr_value;           // assembled modem status
   logic [DATA_W-1:0] rdata_nxt;           // read data for next cycle

   // receive dma path
   logic              dma_mode1;           // multi transfer mode chosen
   dma_state_t        dma_state_r;         // mode 1 request tracker
   dma_state_t        dma_state_nxt;       // next tracker state
   logic              dma_req_nxt;         // request asserted next cycle
   logic              dma_req_prev_r;      // previous request level
   logic              dma_req_start;       // request just went active

   // interrupt path
   logic              modem_irq;           // classic modem status source
   logic              evt_irq;             // masked sticky events
   logic [EVT_W-1:0]  evt_set;             // events this cycle
   logic [EVT_W-1:0]  evt_clear;           // software clear mask

   // ------------------------------------------------------------
   // ring indicator input
   // ------------------------------------------------------------

   // the pin is asynchronous; a raw sample could glitch the flag
   pin_sync3 ring_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin_in  (ring_in_n),
      .level_r (ring_sync_n)
   );

   // pin is active low, status reports the asserted sense
   assign ring_level = ~ring_sync_n;

   // remember the last filtered level for edge detection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ring_prev_r <= RST_LOW;
      end else begin
         ring_prev_r <= ring_level;
      end
   end

   // only the low to high transition counts, falls are ignored
   assign ring_rise = ring_level & ~ring_prev_r;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------

   // a status read is also the clear event for the change flag
   assign msr_read = reg_req.rd && (reg_req.addr == OFS_MODEM_STS);

   // change flag: set wins over the read that would clear it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ring_rise_flag <= RST_LOW;
      end else if (ring_rise) begin
         ring_rise_flag <= RST_HIGH;
      end else if (msr_read) begin
         ring_rise_flag <= RST_LOW;
      end
   end

   // modem status layout; other modem lines live elsewhere
   always_comb begin
      msr_value = RST_REG;
      msr_value[MSR_RING_LVL]  = ring_level;
      msr_value[MSR_RING_RISE] = ring_rise_flag;
   end

   // modem control register write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         modem_control_reg <= RST_REG;
      end else if (reg_req.wr && reg_req.addr == OFS_MODEM_CTL) begin
         modem_control_reg <= reg_req.wdata;
      end
   end

   // fifo control register write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fifo_control_reg <= RST_REG;
      end else if (reg_req.wr && reg_req.addr == OFS_FIFO_CTRL) begin
         fifo_control_reg <= reg_req.wdata;
      end
   end

   // interrupt enable register write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_enable_r <= RST_REG;
      end else if (reg_req.wr && reg_req.addr == OFS_IRQ_EN) begin
         irq_enable_r <= reg_req.wdata;
      end
   end

   // event mask register write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         evt_enable_r <= '0;
      end else if (reg_req.wr && reg_req.addr == OFS_EVT_EN) begin
         evt_enable_r <= reg_req.wdata[EVT_W-1:0];
      end
   end

   // read mux; unmapped and write only offsets read as zero
   always_comb begin
      rdata_nxt = RST_REG;
      if (reg_req.rd) begin
         case (reg_req.addr)
            OFS_IRQ_EN: begin
               rdata_nxt = irq_enable_r;
            end
            OFS_FIFO_CTRL: begin
               rdata_nxt = fifo_control_reg;
            end
            OFS_MODEM_CTL: begin
               rdata_nxt = modem_control_reg;
            end
            OFS_MODEM_STS: begin
               rdata_nxt = msr_value;
            end
            OFS_EVT_STS: begin
               rdata_nxt[EVT_W-1:0] = evt_status_r;
            end
            OFS_EVT_EN: begin
               rdata_nxt[EVT_W-1:0] = evt_enable_r;
            end
            default: begin
               rdata_nxt = RST_REG;
            end
         endcase
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= RST_REG;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // request to send and loopback
   // ------------------------------------------------------------

   // loopback flag is shared with the serial engines
   assign loopback = modem_control_reg[MCR_LOOPBACK];

   // rts only leaves the chip; nothing here feeds it back inward
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rts_n <= RST_HIGH;
      end else if (loopback || !modem_control_reg[MCR_RTS]) begin
         rts_n <= RST_HIGH;
      end else begin
         rts_n <= RST_LOW;
      end
   end

   // ------------------------------------------------------------
   // serial transmit output
   // ------------------------------------------------------------

   // idle line must read marking from reset on
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_out <= RST_HIGH;
      end else begin
         tx_out <= tx_serial_bit;
      end
   end

   // ------------------------------------------------------------
   // receive dma request
   // ------------------------------------------------------------

   // mode 1 only exists with the fifo on; otherwise mode 0
   assign dma_mode1 = fifo_control_reg[FCR_FIFO_EN] &
                      fifo_control_reg[FCR_DMA_MODE];

   // mode 1 tracker: arm on trigger or timeout, drop when empty
   always_comb begin
      dma_state_nxt = dma_state_r;
      case (dma_state_r)
         DMA_IDLE: begin
            if (rx_state.trigger_hit || rx_state.timeout_hit) begin
               dma_state_nxt = DMA_ACTIVE;
            end
         end
         DMA_ACTIVE: begin
            if (!rx_state.data_avail) begin
               dma_state_nxt = DMA_IDLE;
            end
         end
         default: begin
            dma_state_nxt = DMA_IDLE;
         end
      endcase
   end

   // tracker runs in both modes so a mode switch starts clean
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dma_state_r <= DMA_IDLE;
      end else begin
         dma_state_r <= dma_state_nxt;
      end
   end

   // mode 0 follows occupancy; mode 1 follows the tracker
   always_comb begin
      if (dma_mode1) begin
         dma_req_nxt = (dma_state_nxt == DMA_ACTIVE);
      end else begin
         dma_req_nxt = rx_state.data_avail;
      end
   end

   // pin is active low; a registered drive avoids decode glitches
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rx_dma_request_n <= RST_HIGH;
      end else begin
         rx_dma_request_n <= ~dma_req_nxt;
      end
   end

   // the controller paces itself; we only hold the level
   // steady so single or burst transfers both see it cleanly
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dma_req_prev_r <= RST_LOW;
      end else begin
         dma_req_prev_r <= ~rx_dma_request_n;
      end
   end

   // start of a request is reported as an event
   assign dma_req_start = ~rx_dma_request_n & ~dma_req_prev_r;

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------

   // events seen in this cycle
   always_comb begin
      evt_set = '0;
      evt_set[EVT_RING_RISE] = ring_rise;
      evt_set[EVT_DMA_REQ]   = dma_req_start;
   end

   // write only clear register, one bit per event
   always_comb begin
      evt_clear = '0;
      if (reg_req.wr && reg_req.addr == OFS_EVT_CLR) begin
         evt_clear = reg_req.wdata[EVT_W-1:0];
      end
   end

   // sticky bits; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         evt_status_r <= '0;
      end else begin
         evt_status_r <= (evt_status_r & ~evt_clear) | evt_set;
      end
   end

   // classic source: pending until the status read services it
   assign modem_irq = irq_enable_r[IER_MODEM_STS] & ring_rise_flag;

   // masked sticky events
   assign evt_irq = |(evt_status_r & evt_enable_r);

   // level output; drops when serviced, low through reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq <= RST_LOW;
      end else begin
         irq <= modem_irq | evt_irq;
      end
   end

endmodule

/* File: dv/uart_pins_sva.sv */
`timescale 1ns/1ps

// pin checks against shadows of the control registers
module uart_pins_sva
   import uart_pins_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              reset,
   input wire reg_req_t          reg_req,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire rx_state_t         rx_state,
   input wire logic              tx_serial_bit,
   input wire logic              ring_in_n,
   input wire logic              rts_n,
   input wire logic              rx_dma_request_n,
   input wire logic              tx_out,
   input wire logic              irq,
   input wire logic              loopback
);
   logic [7:0] mcr_m_r;  // modem control shadow
   logic [7:0] fcr_m_r;  // fifo control shadow
   logic [3:0] still_r;  // cycles the ring pin has been quiet, saturating
   logic       ring_d_r; // ring pin one cycle ago
   logic       mode1;    // dma mode 1 in the shadow
   logic       msr_rd;   // modem status read strobe
   logic       avail;    // receive data present
   logic       kick;     // trigger or time-out reached
   logic       rts_want; // rts bit set outside loopback
   assign mode1 = fcr_m_r[FCR_FIFO_EN] & fcr_m_r[FCR_DMA_MODE];
   assign msr_rd = reg_req.rd && reg_req.addr == OFS_MODEM_STS;
   assign avail = rx_state.data_avail;
   assign kick = rx_state.trigger_hit | rx_state.timeout_hit;
   assign rts_want = mcr_m_r[MCR_RTS] & ~mcr_m_r[MCR_LOOPBACK];

   // shadows take host writes with the same delay as the real registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mcr_m_r <= RST_REG;
         fcr_m_r <= RST_REG;
      end else if (reg_req.wr && reg_req.addr == OFS_MODEM_CTL) begin
         mcr_m_r <= reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == OFS_FIFO_CTRL) begin
         fcr_m_r <= reg_req.wdata;
      end
   end

   // the filter latency is only trusted once the pin has been quiet a while
   always_ff @(posedge clk_sys) begin
      ring_d_r <= ring_in_n;
      if (reset || ring_in_n != ring_d_r) still_r <= 4'h0;
      else if (still_r != 4'hf) still_r <= still_r + 4'h1;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   AST_RST_LEVELS: assert property ($past(reset) |-> rts_n && rx_dma_request_n && tx_out && !irq)
      else $error("outputs not at reset levels");
   AST_RTS_LEVEL: assert property (!$past(reset) |-> rts_n == !$past(rts_want))
      else $error("rts level does not follow control bits");
   AST_LOOP_FLAG: assert property (loopback == mcr_m_r[MCR_LOOPBACK])
      else $error("loopback flag wrong");
   AST_TX_COPY: assert property (!$past(reset) |-> tx_out == $past(tx_serial_bit))
      else $error("serial output not a copy of the engine bit");
   AST_DMA0: assert property (!$past(reset) && !$past(mode1) |-> rx_dma_request_n == !$past(avail))
      else $error("mode 0 request wrong");
   AST_DMA1_START: assert property (mode1 && avail && kick |=> !rx_dma_request_n)
      else $error("mode 1 request not raised");
   AST_DMA1_HOLD: assert property (mode1 && avail && !rx_dma_request_n |=> !rx_dma_request_n)
      else $error("mode 1 request dropped early");
   AST_DMA1_END: assert property (mode1 && !avail && !kick |=> rx_dma_request_n)
      else $error("mode 1 request kept when empty");
   AST_RING_LVL: assert property (msr_rd && still_r == 4'hf |=> reg_rdata[MSR_RING_LVL] == !$past(ring_in_n))
      else $error("ring level wrong in status");
   AST_RISE_CLR: assert property (msr_rd && $past(msr_rd) && still_r == 4'hf |=> !reg_rdata[MSR_RING_RISE])
      else $error("ring rise flag survived a read");
endmodule

bind uart_modem_rx_dma_pins uart_pins_sva i_uart_pins_sva (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .rx_state(rx_state), .tx_serial_bit(tx_serial_bit), .ring_in_n(ring_in_n),
   .rts_n(rts_n), .rx_dma_request_n(rx_dma_request_n), .tx_out(tx_out), .irq(irq), .loopback(loopback));

/* File: dv/modem_dma_partner.sv */
`timescale 1ns/1ps

// modem ring line plus receive fifo and dma controller draining it
module modem_dma_partner
   import uart_pins_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       ring_on,          // ring indication asserted
   input  wire logic       load,             // push characters this cycle
   input  wire logic [4:0] load_cnt,         // characters pushed
   input  wire logic       age_out,          // time-out pulse
   input  wire logic       burst,            // controller bursts (mode 1 style)
   input  wire logic       rx_dma_request_n,
   output logic            ring_in_n,
   output rx_state_t       rx_state,
   output logic [4:0]      fill_r
);
   localparam logic [4:0] TRIG_LVL = 5'h04; // trigger level of the model fifo
   logic gap_r; // cpu slot after a single transfer
   logic take;  // one character moved this cycle
   // single transfers leave a cycle free between them; bursts do not
   assign take = !rx_dma_request_n && fill_r != 5'h00 && (burst || !gap_r);

   // fifo fill and pacing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fill_r <= 5'h00;
         gap_r <= 1'b0;
      end else begin
         fill_r <= fill_r + (load ? load_cnt : 5'h00) - {4'h0, take};
         gap_r <= take & ~burst;
      end
   end

   // ring line idles high through its pull-up
   assign ring_in_n = !ring_on;
   // time-out only counts while data waits
   assign rx_state = '{data_avail: fill_r != 5'h00, trigger_hit: fill_r >= TRIG_LVL,
                       timeout_hit: age_out && fill_r != 5'h00};
endmodule

/* File: dv/uart_modem_rx_dma_pins_test.sv */
`timescale 1ns/1ps

module uart_modem_rx_dma_pins_test;
   import uart_pins_pkg::*;
   logic              clk_sys, reset, tx_serial_bit, ring_in_n, rts_n, rx_dma_request_n;
   logic              tx_out, irq, loopback, ring_on, load, age_out, burst;
   reg_req_t          reg_req;
   rx_state_t         rx_state;
   logic [DATA_W-1:0] reg_rdata;
   logic [4:0]        load_cnt, fill;
   int                miscompares = 0;
   int                n_tests = 0;
   logic [3:0]        ofs [5] = '{OFS_IRQ_EN, OFS_FIFO_CTRL, OFS_MODEM_CTL, OFS_EVT_STS, OFS_EVT_CLR};

   // 125 MHz
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   uart_modem_rx_dma_pins i_uart_modem_rx_dma_pins (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .rx_state(rx_state), .tx_serial_bit(tx_serial_bit), .ring_in_n(ring_in_n),
      .rts_n(rts_n), .rx_dma_request_n(rx_dma_request_n), .tx_out(tx_out), .irq(irq), .loopback(loopback));
   modem_dma_partner i_modem_dma_partner (.clk_sys(clk_sys), .reset(reset), .ring_on(ring_on), .load(load),
      .load_cnt(load_cnt), .age_out(age_out), .burst(burst), .rx_dma_request_n(rx_dma_request_n),
      .ring_in_n(ring_in_n), .rx_state(rx_state), .fill_r(fill));

   task automatic give_verdict();
      $display("counts: %0d mismatches in %0d comparisons", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   // settle just after an edge before looking
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask
   // one or two (n) back-to-back reads of one offset, each checked in its answer cycle
   task automatic rd_regs(input logic [3:0] a, input logic [7:0] e1, input logic [7:0] e2, input int n);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      if (n == 1) reg_req.rd <= 1'b0;
      #1 chk_byte(reg_rdata, e1);
      if (n == 2) begin
         @(posedge clk_sys);
         reg_req.rd <= 1'b0;
         #1 chk_byte(reg_rdata, e2);
      end
   endtask
   task automatic push(input logic [4:0] n);
      @(posedge clk_sys);
      load <= 1'b1;
      load_cnt <= n;
      @(posedge clk_sys);
      load <= 1'b0;
   endtask
   // a wait that runs out ends the run
   task automatic wait_req(input logic lvl);
      for (int i = 0; i < 200 && rx_dma_request_n !== lvl; i++) cyc(1);
      if (rx_dma_request_n !== lvl) begin
         miscompares++;
         $display("wrong value at %0t: dma request wait ran out", $time);
         give_verdict();
      end
   endtask

   initial begin
      reset = 1'b1;
      reg_req = '0;
      tx_serial_bit = 1'b1;
      ring_on = 1'b0;
      load = 1'b0;
      load_cnt = 5'h00;
      age_out = 1'b0;
      burst = 1'b0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      #1 chk_bit(rts_n & rx_dma_request_n, 1'b1);
      chk_bit(tx_out, 1'b1);
      chk_bit(irq, 1'b0);
      cyc(20);
      rd_regs(OFS_MODEM_STS, 8'h00, 8'h00, 1);
      foreach (ofs[i]) rd_regs(ofs[i], RST_REG, RST_REG, 1);
      wr_reg(4'hf, 8'hff);
      rd_regs(4'hf, 8'h00, 8'h00, 1);
      // rts follows its bit, goes inactive in loopback and on clear
      wr_reg(OFS_MODEM_CTL, 8'h02);
      cyc(2);
      chk_bit(rts_n, 1'b0);
      @(posedge clk_sys) tx_serial_bit <= 1'b0;
      cyc(1);
      chk_bit(tx_out, 1'b0);
      wr_reg(OFS_MODEM_CTL, 8'h12);
      cyc(2);
      chk_bit(rts_n & loopback, 1'b1);
      wr_reg(OFS_MODEM_CTL, 8'h02);
      wr_reg(OFS_MODEM_CTL, 8'h00);
      cyc(2);
      chk_bit(rts_n, 1'b1);
      // ring assertion sets level, flag and interrupt; read clears the flag
      wr_reg(OFS_IRQ_EN, 8'h08);
      @(posedge clk_sys) ring_on <= 1'b1;
      cyc(20);
      chk_bit(irq, 1'b1);
      rd_regs(OFS_MODEM_STS, 8'h44, 8'h40, 2);
      cyc(2);
      chk_bit(irq, 1'b0);
      rd_regs(OFS_EVT_STS, 8'h01, 8'h00, 1);
      wr_reg(OFS_EVT_EN, 8'h01);
      cyc(2);
      chk_bit(irq, 1'b1);
      wr_reg(OFS_EVT_CLR, 8'h01);
      cyc(2);
      chk_bit(irq, 1'b0);
      // release and a one-cycle glitch set nothing
      @(posedge clk_sys) ring_on <= 1'b0;
      cyc(20);
      rd_regs(OFS_MODEM_STS, 8'h00, 8'h00, 1);
      @(posedge clk_sys) ring_on <= 1'b1;
      @(posedge clk_sys) ring_on <= 1'b0;
      cyc(20);
      rd_regs(OFS_MODEM_STS, 8'h00, 8'h00, 1);
      // mode 0 with fifo, then dma bit without fifo still mode 0
      wr_reg(OFS_FIFO_CTRL, 8'h01);
      push(5'h03);
      wait_req(1'b0);
      wait_req(1'b1);
      chk_byte({3'h0, fill}, 8'h00);
      wr_reg(OFS_FIFO_CTRL, 8'h08);
      push(5'h01);
      wait_req(1'b0);
      wait_req(1'b1);
      // mode 1: one character waits for the time-out, four reach the trigger
      wr_reg(OFS_FIFO_CTRL, 8'h09);
      @(posedge clk_sys) burst <= 1'b1;
      push(5'h01);
      cyc(10);
      chk_bit(rx_dma_request_n, 1'b1);
      @(posedge clk_sys) age_out <= 1'b1;
      @(posedge clk_sys) age_out <= 1'b0;
      wait_req(1'b0);
      wait_req(1'b1);
      push(5'h04);
      wait_req(1'b0);
      wait_req(1'b1);
      chk_byte({3'h0, fill}, 8'h00);
      rd_regs(OFS_EVT_STS, 8'h02, 8'h00, 1);
      // second reset in mid-run
      @(posedge clk_sys) reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      #1 chk_bit(tx_out, 1'b1);
      rd_regs(OFS_FIFO_CTRL, RST_REG, RST_REG, 1);
      give_verdict();
   end
endmodule
